// *** verilog/tsm_host.sv ***
// Controller end: register port, serial sequencer for sensor transactions, interrupt.
// Assumes a single target that never stretches the clock and one software master.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module tsm_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  tsm_smbus_if.host        bus,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  output logic             irq
);

  typedef struct packed {
    tsm_pkg::tsm_host_state_e st;
    logic [1:0]               q;
    logic [4:0]               qCnt;
    logic [1:0]               op;
    logic [7:0]               txData;
    logic [7:0]               rxData;
    logic [7:0]               rxShift;
    logic [7:0]               shifter;
    logic [2:0]               byteIdx;
    logic [3:0]               bitIdx;
    logic                     ackBit;
    logic                     nackSeen;
    logic                     scl;
    logic                     sda;
    logic                     alertPrev;
    logic [2:0]               irqStat;
    logic [2:0]               irqMask;
    logic [7:0]               rdData;
    logic                     irq;
  } tsm_host_s;

  localparam logic [4:0] Q_LAST = 5'(tsm_pkg::QUARTER_CYCLES - 1);

  tsm_host_s r;
  tsm_host_s next_r;

  logic       tick;
  logic       sdaBit;
  logic [2:0] irqSet;
  logic [7:0] txByte;

  always_comb begin
    next_r = r;
    irqSet = '0;
    tick   = (r.st != tsm_pkg::TSM_H_IDLE) && (r.qCnt == Q_LAST);
    next_r.alertPrev = bus.alertN;
    if (r.alertPrev && !bus.alertN) begin
      irqSet[tsm_pkg::IRQ_ALERT_BIT] = 1'b1;
    end

    if (r.st != tsm_pkg::TSM_H_IDLE) begin
      next_r.qCnt = tick ? 5'h00 : r.qCnt + 5'h01;
    end

    // Start a transaction; ignored while busy
    if (regWr && regAddr == tsm_pkg::REG_CTRL && r.st == tsm_pkg::TSM_H_IDLE &&
        regWrData[1:0] != tsm_pkg::OP_NONE) begin
      next_r.st       = tsm_pkg::TSM_H_START;
      next_r.op       = regWrData[1:0];
      next_r.q        = 2'h0;
      next_r.qCnt     = 5'h00;
      next_r.byteIdx  = 3'h0;
      next_r.nackSeen = 1'b0;
      next_r.scl      = 1'b0;
      next_r.sda      = 1'b1;
    end else if (tick) begin
      if (r.st == tsm_pkg::TSM_H_BIT && r.q == 2'h2) begin
        if (r.bitIdx[3]) begin
          next_r.ackBit = bus.sda;
        end else begin
          next_r.rxShift = {r.rxShift[6:0], bus.sda};
        end
      end
      if (r.q != 2'h3) begin
        next_r.q = r.q + 2'h1;
      end else begin
        next_r.q = 2'h0;
        case (r.st)
          tsm_pkg::TSM_H_START: begin
            next_r.st     = tsm_pkg::TSM_H_BIT;
            next_r.bitIdx = 4'h0;
          end
          tsm_pkg::TSM_H_BIT: begin
            next_r.bitIdx = r.bitIdx + 4'h1;
            if (r.bitIdx[3]) begin
              next_r.bitIdx = 4'h0;
              if (r.byteIdx != 3'h4 && r.ackBit) begin
                next_r.nackSeen = 1'b1;
                irqSet[tsm_pkg::IRQ_NACK_BIT] = 1'b1;
                next_r.st = tsm_pkg::TSM_H_STOP;
              end else if (r.byteIdx == 3'h4) begin
                next_r.rxData = r.rxShift & tsm_pkg::CFG_IMPL_BITS;
                next_r.st     = tsm_pkg::TSM_H_STOP;
              end else if (r.byteIdx == 3'h1) begin
                if (r.op == tsm_pkg::OP_WRITE) begin
                  next_r.byteIdx = 3'h2;
                end else if (r.op == tsm_pkg::OP_READ) begin
                  next_r.byteIdx = 3'h3;
                  next_r.st      = tsm_pkg::TSM_H_START;
                end else begin
                  // One-shot fetches no result byte
                  next_r.st = tsm_pkg::TSM_H_STOP;
                end
              end else if (r.byteIdx == 3'h2) begin
                next_r.st = tsm_pkg::TSM_H_STOP;
              end else begin
                next_r.byteIdx = r.byteIdx + 3'h1;
              end
            end
          end
          default: begin
            next_r.st = tsm_pkg::TSM_H_IDLE;
            irqSet[tsm_pkg::IRQ_DONE_BIT] = 1'b1;
          end
        endcase
      end
    end

    // Byte to send for the (possibly new) byte slot
    case (next_r.byteIdx)
      3'h0: txByte = {tsm_pkg::SENSOR_ADDR, 1'b0};
      3'h1: txByte = (next_r.op == tsm_pkg::OP_WRITE) ? tsm_pkg::CMD_WRITE_CFG :
                     (next_r.op == tsm_pkg::OP_READ) ? tsm_pkg::CMD_READ_CFG : tsm_pkg::CMD_ONE_SHOT;
      3'h2: txByte = next_r.txData & tsm_pkg::CFG_IMPL_BITS;
      3'h3: txByte = {tsm_pkg::SENSOR_ADDR, 1'b1};
      default: txByte = 8'hff;
    endcase
    if (tick && next_r.st == tsm_pkg::TSM_H_BIT && next_r.q == 2'h0 && next_r.bitIdx == 4'h0) begin
      next_r.shifter = txByte;
    end
    sdaBit = next_r.bitIdx[3] | (next_r.byteIdx == 3'h4) | next_r.shifter[~next_r.bitIdx[2:0]];

    // Line levels per quarter of each slot
    if (tick) begin
      case (next_r.st)
        tsm_pkg::TSM_H_START: begin
          next_r.scl = (next_r.q == 2'h1) | (next_r.q == 2'h2);
          next_r.sda = (next_r.q == 2'h0) | (next_r.q == 2'h1);
        end
        tsm_pkg::TSM_H_BIT: begin
          next_r.scl = (next_r.q == 2'h1) | (next_r.q == 2'h2);
          next_r.sda = sdaBit;
        end
        tsm_pkg::TSM_H_STOP: begin
          next_r.scl = (next_r.q != 2'h0);
          next_r.sda = next_r.q[1];
        end
        default: begin
          next_r.scl = 1'b1;
          next_r.sda = 1'b1;
        end
      endcase
    end

    // Register port
    next_r.rdData = 8'h00;
    if (regWr) begin
      if (regAddr == tsm_pkg::REG_TXDATA) begin
        next_r.txData = regWrData;
      end else if (regAddr == tsm_pkg::REG_IRQ_MASK) begin
        next_r.irqMask = regWrData[2:0];
      end
    end
    next_r.irqStat = (r.irqStat & ~((regWr && regAddr == tsm_pkg::REG_IRQ_STAT) ? regWrData[2:0] : 3'h0))
                     | irqSet;
    if (regRd) begin
      if (regAddr == tsm_pkg::REG_TXDATA) begin
        next_r.rdData = r.txData;
      end else if (regAddr == tsm_pkg::REG_RXDATA) begin
        next_r.rdData = r.rxData;
      end else if (regAddr == tsm_pkg::REG_STATUS) begin
        next_r.rdData = {5'h00, ~bus.alertN, r.nackSeen, r.st != tsm_pkg::TSM_H_IDLE};
      end else if (regAddr == tsm_pkg::REG_IRQ_STAT) begin
        next_r.rdData = {5'h00, r.irqStat};
      end else if (regAddr == tsm_pkg::REG_IRQ_MASK) begin
        next_r.rdData = {5'h00, r.irqMask};
      end else begin
        next_r.rdData = 8'h00;
      end
    end
    next_r.irq = |(next_r.irqStat & next_r.irqMask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r           <= '0;
      r.st        <= tsm_pkg::TSM_H_IDLE;
      r.scl       <= 1'b1;
      r.sda       <= 1'b1;
      r.alertPrev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.hostSclOut = 1'b0;
  assign bus.hostSclOe  = ~r.scl;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe  = ~r.sda;
  assign regRdData      = r.rdData;
  assign irq            = r.irq;

endmodule // tsm_host

// *** verilog/tsm_pkg.sv ***
// Shared constants and types for the thermal sensor mode control block.
// Assumes one 10 MHz system clock shared by both ends of the serial link.
package tsm_pkg;

  // Clock and serial timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CLK_HZ         = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int SCL_HZ         = 100_000;
  localparam int QUARTER_CYCLES = CLK_HZ / (SCL_HZ * 4);
  localparam int CONV_TIME_NS   = 100_000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sensor target address and command codes
  localparam logic [6:0] SENSOR_ADDR   = 7'h4e;
  localparam logic [7:0] CMD_READ_CFG  = 8'h03;
  localparam logic [7:0] CMD_WRITE_CFG = 8'h09;
  localparam logic [7:0] CMD_ONE_SHOT  = 8'h0f;

  // sensor_operating_config layout
  localparam int         CFG_MASK_BIT    = 7;
  localparam int         CFG_STANDBY_BIT = 6;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] CFG_IMPL_BITS   = 8'hc0;

  // Controller register map (8-bit addresses, 8-bit data)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TXDATA   = 8'h01;
  localparam logic [7:0] REG_RXDATA   = 8'h02;
  localparam logic [7:0] REG_STATUS   = 8'h03;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h05;

  // Operation codes written to REG_CTRL[1:0]
  localparam logic [1:0] OP_NONE     = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_ONE_SHOT = 2'h3;

  // Status and interrupt bit positions
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_NACK_BIT   = 1;
  localparam int ST_ALERT_BIT  = 2;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_NACK_BIT  = 1;
  localparam int IRQ_ALERT_BIT = 2;
  localparam int IRQ_WIDTH     = 3;

  typedef enum logic [2:0] {
    TSM_D_IDLE,
    TSM_D_RX,
    TSM_D_ACK,
    TSM_D_TX,
    TSM_D_WAIT
  } tsm_dev_state_e;

  typedef enum logic [2:0] {
    TSM_H_IDLE,
    TSM_H_START,
    TSM_H_BIT,
    TSM_H_STOP
  } tsm_host_state_e;

endpackage

// *** verilog/tsm_smbus_if.sv ***
// Two-wire serial link plus alert line between controller and sensor.
// Assumes external pull-ups: a wire is low while any driver enables a low output.
`timescale 1ns/100ps
interface tsm_smbus_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic devAlertOut;
  logic devAlertOe;
  logic scl;
  logic sda;
  logic alertN;

  assign scl    = ~(hostSclOe & ~hostSclOut);
  assign sda    = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
  assign alertN = ~(devAlertOe & ~devAlertOut);

  modport host (
    output hostSclOut,
    output hostSclOe,
    output hostSdaOut,
    output hostSdaOe,
    input  scl,
    input  sda,
    input  alertN
  );

  modport dev (
    output devSdaOut,
    output devSdaOe,
    output devAlertOut,
    output devAlertOe,
    input  scl,
    input  sda
  );
endinterface

// *** verilog/tsm_sensor.sv ***
// Sensor end: serial target, operating configuration, conversion engine, alert.
// Assumes scl/sda are synchronous to clk and the controller never stretches.
`timescale 1ns/100ps
module tsm_sensor (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  tsm_smbus_if.dev         bus,
  input  wire logic [7:0]  diodeTempIn,
  input  wire logic [7:0]  localTempIn,
  input  wire logic [7:0]  upperLimit,
  input  wire logic [7:0]  lowerLimit,
  output logic      [7:0]  diodeTemp,
  output logic      [7:0]  localTemp,
  output logic      [7:0]  operatingConfig,
  output logic             converting,
  output logic             convDone,
  output logic             alertActive
);

  typedef struct packed {
    tsm_pkg::tsm_dev_state_e st;
    logic                    sclPrev;
    logic                    sdaPrev;
    logic [7:0]              shifter;
    logic [2:0]              bitCnt;
    logic                    byteDone;
    logic [1:0]              byteIdx;
    logic                    readDir;
    logic [7:0]              cmd;
    logic [7:0]              cfg;
    logic                    sdaLow;
    logic                    converting;
    logic [15:0]             convCnt;
    logic                    convDone;
    logic [7:0]              diodeTemp;
    logic [7:0]              localTemp;
    logic                    alertCond;
    logic                    alertOe;
  } tsm_dev_s;

  localparam logic [15:0] CONV_LAST = 16'(tsm_pkg::CONV_CYCLES - 1);

  tsm_dev_s r;
  tsm_dev_s next_r;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic oneShotReq;
  logic standbyWrite;

  always_comb begin
    next_r       = r;
    next_r.convDone = 1'b0;
    oneShotReq   = 1'b0;
    standbyWrite = 1'b0;
    sclRise      = bus.scl & ~r.sclPrev;
    sclFall      = ~bus.scl & r.sclPrev;
    startCond    = bus.scl & r.sclPrev & r.sdaPrev & ~bus.sda;
    stopCond     = bus.scl & r.sclPrev & ~r.sdaPrev & bus.sda;
    next_r.sclPrev = bus.scl;
    next_r.sdaPrev = bus.sda;

    // Serial target
    if (startCond) begin
      next_r.st       = tsm_pkg::TSM_D_RX;
      next_r.bitCnt   = 3'h0;
      next_r.byteDone = 1'b0;
      next_r.byteIdx  = 2'h0;
      next_r.sdaLow   = 1'b0;
    end else if (stopCond) begin
      next_r.st     = tsm_pkg::TSM_D_IDLE;
      next_r.sdaLow = 1'b0;
    end else begin
      case (r.st)
        tsm_pkg::TSM_D_RX: begin
          if (sclRise) begin
            next_r.shifter  = {r.shifter[6:0], bus.sda};
            next_r.bitCnt   = r.bitCnt + 3'h1;
            next_r.byteDone = (r.bitCnt == 3'h7);
          end else if (sclFall && r.byteDone) begin
            next_r.byteDone = 1'b0;
            case (r.byteIdx)
              2'h0: begin
                if (r.shifter[7:1] == tsm_pkg::SENSOR_ADDR) begin
                  next_r.st      = tsm_pkg::TSM_D_ACK;
                  next_r.sdaLow  = 1'b1;
                  next_r.readDir = r.shifter[0];
                end else begin
                  next_r.st = tsm_pkg::TSM_D_IDLE;
                end
              end
              2'h1: begin
                next_r.cmd    = r.shifter;
                next_r.st     = tsm_pkg::TSM_D_ACK;
                next_r.sdaLow = 1'b1;
                oneShotReq    = (r.shifter == tsm_pkg::CMD_ONE_SHOT);
              end
              2'h2: begin
                if (r.cmd == tsm_pkg::CMD_WRITE_CFG) begin
                  next_r.cfg   = r.shifter & tsm_pkg::CFG_IMPL_BITS;
                  standbyWrite = r.shifter[tsm_pkg::CFG_STANDBY_BIT];
                end
                next_r.st     = tsm_pkg::TSM_D_ACK;
                next_r.sdaLow = 1'b1;
              end
              default: begin
                next_r.st = tsm_pkg::TSM_D_IDLE;
              end
            endcase
          end
        end
        tsm_pkg::TSM_D_ACK: begin
          if (sclFall) begin
            next_r.byteIdx = r.byteIdx + 2'h1;
            next_r.bitCnt  = 3'h0;
            if (r.readDir && r.byteIdx == 2'h0) begin
              // Byte read returns configuration, reserved bits as zero
              next_r.st      = tsm_pkg::TSM_D_TX;
              next_r.shifter = r.cfg;
              next_r.sdaLow  = ~r.cfg[7];
            end else begin
              next_r.st     = tsm_pkg::TSM_D_RX;
              next_r.sdaLow = 1'b0;
            end
          end
        end
        tsm_pkg::TSM_D_TX: begin
          if (sclFall) begin
            if (r.bitCnt == 3'h7) begin
              next_r.st     = tsm_pkg::TSM_D_WAIT;
              next_r.sdaLow = 1'b0;
            end else begin
              next_r.shifter = {r.shifter[6:0], 1'b0};
              next_r.sdaLow  = ~r.shifter[6];
              next_r.bitCnt  = r.bitCnt + 3'h1;
            end
          end
        end
        default: begin
          next_r.sdaLow = 1'b0;
        end
      endcase
    end

    // Conversion engine
    if (standbyWrite) begin
      next_r.converting = 1'b0;
      next_r.convCnt    = 16'h0000;
    end else if (r.converting) begin
      if (r.convCnt == CONV_LAST) begin
        next_r.convCnt    = 16'h0000;
        next_r.convDone   = 1'b1;
        next_r.diodeTemp  = diodeTempIn;
        next_r.localTemp  = localTempIn;
        next_r.alertCond  = ($signed(diodeTempIn) > $signed(upperLimit)) |
                            ($signed(diodeTempIn) < $signed(lowerLimit)) |
                            ($signed(localTempIn) > $signed(upperLimit)) |
                            ($signed(localTempIn) < $signed(lowerLimit));
        next_r.converting = ~r.cfg[tsm_pkg::CFG_STANDBY_BIT];
      end else begin
        next_r.convCnt = r.convCnt + 16'h0001;
      end
    end else if (!r.cfg[tsm_pkg::CFG_STANDBY_BIT]) begin
      next_r.converting = 1'b1;
    end else if (oneShotReq) begin
      next_r.converting = 1'b1;
    end

    // Alert drive gated by the mask bit
    next_r.alertOe = next_r.alertCond & ~next_r.cfg[tsm_pkg::CFG_MASK_BIT];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r            <= '0;
      r.st         <= tsm_pkg::TSM_D_IDLE;
      r.sclPrev    <= 1'b1;
      r.sdaPrev    <= 1'b1;
      r.cfg        <= tsm_pkg::CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign bus.devSdaOut   = 1'b0;
  assign bus.devSdaOe    = r.sdaLow;
  assign bus.devAlertOut = 1'b0;
  assign bus.devAlertOe  = r.alertOe;

  assign diodeTemp       = r.diodeTemp;
  assign localTemp       = r.localTemp;
  assign operatingConfig = r.cfg;
  assign converting      = r.converting;
  assign convDone        = r.convDone;
  assign alertActive     = r.alertOe;

endmodule // tsm_sensor

// *** bench/tsm_sva.sv ***
// Concurrent checks on the serial link and on the sensor mode outputs.
// Assumes it is instantiated in the testbench top beside the link interface.
`timescale 1ns/100ps
module tsm_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       scl,
  input wire logic       alertN,
  input wire logic       devSdaOe,
  input wire logic       devAlertOe,
  input wire logic [7:0] operatingConfig,
  input wire logic       converting,
  input wire logic       convDone,
  input wire logic       alertActive,
  input wire logic [7:0] diodeTemp,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] upperLimit,
  input wire logic [7:0] lowerLimit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_fullConv;
    converting [*8];
  endsequence
  sequence s_rerun;
    ##[1:3] converting;
  endsequence

  property p_resetCfg;
    $past(sys_rst) |-> operatingConfig == 8'h00 && !devAlertOe;
  endproperty
  a_resetCfg: assert property (p_resetCfg) else $error("config or alert not clear after reset");

  property p_reserved;
    operatingConfig[5:0] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved config bits not zero");

  property p_contRerun;
    convDone && !operatingConfig[6] |-> s_rerun;
  endproperty
  a_contRerun: assert property (p_contRerun) else $error("continuous mode did not restart");

  property p_convRuns;
    $rose(converting) && !operatingConfig[6] |-> s_fullConv;
  endproperty
  a_convRuns: assert property (p_convRuns) else $error("conversion cut short");

  property p_standbyStop;
    $rose(operatingConfig[6]) |-> ##[0:2] !converting;
  endproperty
  a_standbyStop: assert property (p_standbyStop) else $error("standby did not stop conversion");

  property p_oneShotCause;
    $rose(converting) && operatingConfig[6] |-> !scl;
  endproperty
  a_oneShotCause: assert property (p_oneShotCause) else $error("standby conversion without command");

  property p_mask;
    operatingConfig[7] && $past(operatingConfig[7]) |-> !devAlertOe && alertN;
  endproperty
  a_mask: assert property (p_mask) else $error("alert driven while masked");

  property p_alertWire;
    convDone |-> alertActive == (!operatingConfig[7] &&
      (($signed(diodeTemp) > $signed(upperLimit)) || ($signed(diodeTemp) < $signed(lowerLimit)) ||
       ($signed(localTemp) > $signed(upperLimit)) || ($signed(localTemp) < $signed(lowerLimit))))
      && alertActive == devAlertOe && alertN == !devAlertOe;
  endproperty
  a_alertWire: assert property (p_alertWire) else $error("alert line disagrees with alert state");

  property p_ackEdge;
    $changed(devSdaOe) |-> !scl;
  endproperty
  a_ackEdge: assert property (p_ackEdge) else $error("sensor changed data while clock high");
endmodule // tsm_sva

// *** bench/smbus_thermal_sensor_mode_control_tb.sv ***
// Self-checking bench: controller and sensor joined by the link interface.
// Assumes the register map and timing of the package; software side is driven here.
`timescale 1ns/100ps
module smbus_thermal_sensor_mode_control_tb;
  logic       clk;
  logic       sys_rst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdData;
  logic       irq;
  logic [7:0] diodeTempIn;
  logic [7:0] localTempIn;
  logic [7:0] upperLimit;
  logic [7:0] lowerLimit;
  logic [7:0] operatingConfig;
  logic       converting;
  logic       convDone;
  logic       alertActive;
  logic [7:0] diodeTemp;
  logic [7:0] localTemp;
  logic [7:0] rdVal;
  logic [7:0] v;
  int         failCount;
  int         nCompared;
  int         seed;
  int         doneCount;
  int         d0;
  logic [7:0] cfgModel;
  logic       alertExp;

  tsm_smbus_if bus ();
  tsm_sensor u_tsm_sensor (.clk(clk), .sys_rst(sys_rst), .bus(bus), .diodeTempIn(diodeTempIn),
    .localTempIn(localTempIn), .upperLimit(upperLimit), .lowerLimit(lowerLimit), .diodeTemp(diodeTemp),
    .localTemp(localTemp), .operatingConfig(operatingConfig), .converting(converting), .convDone(convDone),
    .alertActive(alertActive));
  tsm_host u_tsm_host (.clk(clk), .sys_rst(sys_rst), .bus(bus), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
  tsm_sva u_tsm_sva (.clk(clk), .sys_rst(sys_rst), .scl(bus.scl), .alertN(bus.alertN),
    .devSdaOe(bus.devSdaOe), .devAlertOe(bus.devAlertOe), .operatingConfig(operatingConfig),
    .converting(converting), .convDone(convDone), .alertActive(alertActive), .diodeTemp(diodeTemp),
    .localTemp(localTemp), .upperLimit(upperLimit), .lowerLimit(lowerLimit));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (convDone === 1'b1) doneCount++;
  end

  task automatic summarize;
    $display("compared=%0d mismatches=%0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Starts an operation, polls busy, then checks and clears the done interrupt
  task automatic runOp(input logic [1:0] op);
    int i;
    logic [7:0] s;
    wr(tsm_pkg::REG_CTRL, {6'h00, op});
    for (i = 0; i < 6000; i++) begin
      rd(tsm_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 6000) begin
      failCount++;
      summarize();
    end
    @(posedge clk);
    #1 check({7'h00, irq}, 8'h01);
    wr(tsm_pkg::REG_IRQ_STAT, 8'h01);
    rd(tsm_pkg::REG_IRQ_STAT, s);
    check(s & 8'h03, 8'h00);
  endtask

  task automatic writeCfg(input logic [7:0] d);
    wr(tsm_pkg::REG_TXDATA, d);
    runOp(tsm_pkg::OP_WRITE);
    cfgModel = d & 8'hc0;
    check(operatingConfig, cfgModel);
    runOp(tsm_pkg::OP_READ);
    rd(tsm_pkg::REG_RXDATA, rdVal);
    check(rdVal, cfgModel);
  endtask

  initial begin
    seed = 32'h6782;
    failCount = 0;
    nCompared = 0;
    doneCount = 0;
    cfgModel = 8'h00;
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    diodeTempIn = 8'h20;
    localTempIn = 8'h20;
    upperLimit = 8'h50;
    lowerLimit = 8'h05;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check(operatingConfig, 8'h00);
    rd(8'h07, rdVal);
    check(rdVal, 8'h00);
    wr(tsm_pkg::REG_IRQ_MASK, 8'h01);
    runOp(tsm_pkg::OP_READ);
    rd(tsm_pkg::REG_RXDATA, rdVal);
    check(rdVal, 8'h00);
    for (int k = 0; k < 3; k++) begin
      v = 8'($random(seed));
      writeCfg(v);
    end
    writeCfg(8'h40);
    #1 check({7'h00, converting}, 8'h00);
    d0 = doneCount;
    repeat (tsm_pkg::CONV_CYCLES + 200) @(posedge clk);
    check(8'(doneCount - d0), 8'h00);
    runOp(tsm_pkg::OP_ONE_SHOT);
    repeat (tsm_pkg::CONV_CYCLES + 200) @(posedge clk);
    check(8'(doneCount - d0), 8'h01);
    writeCfg(8'h00);
    d0 = doneCount;
    repeat (2 * tsm_pkg::CONV_CYCLES + 100) @(posedge clk);
    check({7'h00, (doneCount - d0) >= 2}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      diodeTempIn <= v;
      alertExp = ($signed(v) > $signed(upperLimit)) || ($signed(v) < $signed(lowerLimit));
      repeat (2 * tsm_pkg::CONV_CYCLES + 20) @(posedge clk);
      #1 check({7'h00, bus.alertN}, {7'h00, !alertExp});
      check(diodeTemp, v);
      check(localTemp, 8'h20);
    end
    wr(tsm_pkg::REG_IRQ_MASK, 8'h04);
    diodeTempIn <= 8'h10;
    repeat (2 * tsm_pkg::CONV_CYCLES + 20) @(posedge clk);
    diodeTempIn <= 8'h60;
    repeat (2 * tsm_pkg::CONV_CYCLES + 20) @(posedge clk);
    #1 check({7'h00, bus.alertN}, 8'h00);
    check({7'h00, irq}, 8'h01);
    rd(tsm_pkg::REG_STATUS, rdVal);
    check(rdVal, 8'h04);
    wr(tsm_pkg::REG_IRQ_STAT, 8'h04);
    @(posedge clk);
    #1 check({7'h00, irq}, 8'h00);
    wr(tsm_pkg::REG_IRQ_MASK, 8'h01);
    writeCfg(8'h80);
    #1 check({7'h00, bus.alertN}, 8'h01);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 check(operatingConfig, 8'h00);
    check({7'h00, bus.alertN}, 8'h01);
    summarize();
  end
endmodule // smbus_thermal_sensor_mode_control_tb
